// ===== shared/usr_defs.vh
`ifndef USR_DEFS_VH
`define USR_DEFS_VH
// register byte offsets
`define USR_OFS_RX_HOLDING 8'h18
`define USR_OFS_TX_HOLDING 8'h1C
`define USR_OFS_BAUD_DIVIDER 8'h20
`define USR_OFS_RX_IDLE_LIMIT 8'h24
`define USR_OFS_TX_GAP 8'h28
`define USR_OFS_LIN_CONFIG 8'h54
`define USR_OFS_LIN_IDENT 8'h58
`define USR_OFS_WRITE_GUARD 8'hE4
// field layout
`define USR_CHAR_W 9
`define USR_DIVISOR_W 16
`define USR_FRACTION_LSB 16
`define USR_FRACTION_W 3
`define USR_IDLE_LIMIT_W 17
`define USR_GAP_W 8
`define USR_LINCFG_W 17
`define USR_LINCFG_DMA_BIT 16
`define USR_LIN_ROLE_LSB 0
`define USR_LIN_PARITY_OFF_BIT 2
`define USR_LIN_CHECKSUM_OFF_BIT 3
`define USR_LIN_CHECKSUM_KIND_BIT 4
`define USR_LIN_LEN_SRC_BIT 5
`define USR_LIN_SLOT_OFF_BIT 6
`define USR_LIN_WAKE_KIND_BIT 7
`define USR_LIN_COUNT_LSB 8
`define USR_IDENT_W 8
`define USR_GUARD_KEY 24'h555341
`define USR_GUARD_KEY_LSB 8
// reset values
`define USR_RESET_WORD 32'h00000000
// samples per bit in each timing mode
`define USR_SAMPLES_NORMAL 5'h10
`define USR_SAMPLES_OVER 5'h08
`define USR_SAMPLES_SYNC 5'h01
// node response roles
`define USR_ROLE_PUBLISH 2'h0
`define USR_ROLE_SUBSCRIBE 2'h1
`define USR_ROLE_IGNORE 2'h2
`endif

// ===== rtl/usr_baud_gen.v
`timescale 1ns/1ns
`include "usr_defs.vh"
module usr_baud_gen #(
  parameter DIV_W = 16
) (
  input wire clock,
  input wire reset_n,
  input wire ce,
  input wire [DIV_W-1:0] divisor,
  input wire [2:0] fraction,
  input wire [4:0] samplesPerBit,
  output reg sampleTick,
  output reg bitTick
);
  reg [DIV_W-1:0] clkCnt_q;
  reg [2:0] fracAcc_q;
  reg extraCycle_q;
  reg [4:0] sampleCnt_q;
  wire [3:0] fracSum = {1'b0, fracAcc_q} + {1'b0, fraction};
  wire periodEnd = (clkCnt_q == divisor - 1'b1) && !extraCycle_q;

  // divisor count, then one extra cycle whenever eighths overflow
  always @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      clkCnt_q <= {DIV_W{1'b0}};
      fracAcc_q <= 3'h0;
      extraCycle_q <= 1'b0;
      sampleTick <= 1'b0;
      sampleCnt_q <= 5'h00;
      bitTick <= 1'b0;
    end else if (ce) begin
      sampleTick <= 1'b0;
      bitTick <= 1'b0;
      if (divisor == {DIV_W{1'b0}}) begin
        clkCnt_q <= {DIV_W{1'b0}};
        extraCycle_q <= 1'b0;
        sampleCnt_q <= 5'h00;
      end else if (extraCycle_q) begin
        extraCycle_q <= 1'b0;
        sampleTick <= 1'b1;
      end else if (periodEnd) begin
        clkCnt_q <= {DIV_W{1'b0}};
        fracAcc_q <= fracSum[2:0];
        if (fracSum[3])
          extraCycle_q <= 1'b1;
        else
          sampleTick <= 1'b1;
      end else begin
        clkCnt_q <= clkCnt_q + 1'b1;
      end
      // bit period is samplesPerBit sample periods
      if (sampleTick) begin
        if (sampleCnt_q >= samplesPerBit - 1'b1) begin
          sampleCnt_q <= 5'h00;
          bitTick <= 1'b1;
        end else begin
          sampleCnt_q <= sampleCnt_q + 1'b1;
        end
      end
    end
  end
endmodule

// ===== rtl/usr_bit_timer.v
`timescale 1ns/1ns
module usr_bit_timer #(
  parameter W = 8
) (
  input wire clock,
  input wire reset_n,
  input wire ce,
  input wire start,
  input wire [W-1:0] limit,
  input wire bitTick,
  output reg running,
  output reg expire
);
  reg [W-1:0] left_q;

  // counts limit bit periods; a zero limit never starts
  always @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      left_q <= {W{1'b0}};
      running <= 1'b0;
      expire <= 1'b0;
    end else if (ce) begin
      expire <= 1'b0;
      if (start) begin
        left_q <= limit;
        running <= (limit != {W{1'b0}});
      end else if (running && bitTick) begin
        left_q <= left_q - 1'b1;
        if (left_q == {{(W-1){1'b0}}, 1'b1}) begin
          running <= 1'b0;
          expire <= 1'b1;
        end
      end
    end
  end
endmodule

// ===== rtl/usr_regs.v
// Overview of operation
// - tx_holding write holds the next character while transmit flag low.
// - baud, idle limit and gap writes ignored while write guard on.
// - fraction step zero disables; 1..7 adds that many eighths.
// - divisor zero stops the baud clock entirely.
// - async normal mode bit rate is clock / 16 / divisor.
// - async oversampling mode bit rate is clock / 8 / divisor.
// - sync or SPI mode bit rate is clock / divisor.
// - idle limit zero keeps receiver time-out disabled.
// - idle limit 1..131071 times out after that many bit periods.
// - gap count zero inserts no idle time between characters.
// - gap count 1..255 waits that many bit periods between characters.
// - with DMA bit set, lin_config other bits load from DMA.
// - length source zero gives byte count field plus one bytes.
// - wake command sends 2.0 style if kind zero, 1.3 if one.
// - slot timing active when its off bit is zero.
// - length source one takes length from ident bits 5 and 4.
// - checksum kind zero is enhanced, one is classic.
// - checksum off clear computes and checks checksum; set skips both.
// - parity off clear sends and checks ident parity; set skips both.
// - node role 0 transmit, 1 receive, 2 neither, 3 reserved.
// - ident writable in master mode, shows received ident in slave.
//
// Implementation choice: the Avalon-MM interface to the registers.
`timescale 1ns/1ns
`include "usr_defs.vh"
module usr_regs #(
  parameter DIV_W = `USR_DIVISOR_W,
  parameter IDLE_W = `USR_IDLE_LIMIT_W,
  parameter GAP_W = `USR_GAP_W
) (
  input wire clock,
  input wire reset_n,
  input wire ce,
  // avalon-mm slave
  input wire [7:0] address,
  input wire read,
  input wire write,
  input wire [31:0] writedata,
  output reg [31:0] readdata,
  output reg waitrequest,
  // mode straps from the mode register
  input wire syncMode,
  input wire overSample,
  input wire linMaster,
  // character path
  input wire rxCharValid,
  input wire [8:0] rxChar,
  input wire txCharTaken,
  input wire txCharDone,
  input wire rxStartTimeout,
  output reg [8:0] charToSend,
  output reg transmitFreeFlag,
  // timing
  output reg baudSample,
  output reg baudBit,
  output reg rxIdleTimedOut,
  output reg txGapHold,
  // lin side
  input wire linIdentValid,
  input wire [7:0] linIdentIn,
  input wire linDmaValid,
  input wire [15:0] linDmaData,
  input wire sendWakeCmd,
  output reg [7:0] linIdentOut,
  output reg [8:0] respByteCount,
  output reg wakeV20,
  output reg wakeV13,
  output reg slotTimingOn,
  output reg checksumEnhanced,
  output reg checksumOn,
  output reg parityOn,
  output reg respTransmit,
  output reg respReceive,
  output reg guardOn
);
  reg [8:0] rxHolding_q;
  reg [DIV_W-1:0] divisor_q;
  reg [2:0] fraction_q;
  reg [IDLE_W-1:0] idleLimit_q;
  reg [GAP_W-1:0] gapCount_q;
  reg [`USR_LINCFG_W-1:0] linCfg_q;
  reg [7:0] ident_q;
  reg [31:0] readWord_d;
  reg [4:0] samplesPerBit_d;
  reg [8:0] respLen_d;
  wire busWrite = write && !waitrequest;
  wire guardKeyOk =
    (writedata[31:`USR_GUARD_KEY_LSB] == `USR_GUARD_KEY);
  wire sampleTick;
  wire bitTick;
  wire idleExpire;
  wire gapRunning;
  wire dmaMode = linCfg_q[`USR_LINCFG_DMA_BIT];
  wire [1:0] role = linCfg_q[`USR_LIN_ROLE_LSB+1:`USR_LIN_ROLE_LSB];

  // bus answers one cycle after the request is seen, for one cycle
  always @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      waitrequest <= 1'b1;
      readdata <= `USR_RESET_WORD;
    end else if (ce) begin
      if (waitrequest && (read || write)) begin
        waitrequest <= 1'b0;
        readdata <= read ? readWord_d : `USR_RESET_WORD;
      end else begin
        waitrequest <= 1'b1;
      end
    end
  end

  // read decode; unmapped and write-only offsets read zero
  always @* begin
    readWord_d = `USR_RESET_WORD;
    if (address == `USR_OFS_RX_HOLDING)
      readWord_d[8:0] = rxHolding_q;
    else if (address == `USR_OFS_BAUD_DIVIDER) begin
      readWord_d[DIV_W-1:0] = divisor_q;
      readWord_d[`USR_FRACTION_LSB+2:`USR_FRACTION_LSB] = fraction_q;
    end else if (address == `USR_OFS_RX_IDLE_LIMIT)
      readWord_d[IDLE_W-1:0] = idleLimit_q;
    else if (address == `USR_OFS_TX_GAP)
      readWord_d[GAP_W-1:0] = gapCount_q;
    else if (address == `USR_OFS_LIN_CONFIG)
      readWord_d[`USR_LINCFG_W-1:0] = linCfg_q;
    else if (address == `USR_OFS_LIN_IDENT)
      readWord_d[7:0] = ident_q;
    else if (address == `USR_OFS_WRITE_GUARD)
      readWord_d[0] = guardOn;
  end

  // write guard: enable bit moves only with the key in the same word
  always @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      guardOn <= 1'b0;
    end else if (ce) begin
      if (busWrite && address == `USR_OFS_WRITE_GUARD && guardKeyOk)
        guardOn <= writedata[0];
    end
  end

  // protected timing registers
  always @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      divisor_q <= {DIV_W{1'b0}};
      fraction_q <= 3'h0;
      idleLimit_q <= {IDLE_W{1'b0}};
      gapCount_q <= {GAP_W{1'b0}};
    end else if (ce && busWrite && !guardOn) begin
      if (address == `USR_OFS_BAUD_DIVIDER) begin
        divisor_q <= writedata[DIV_W-1:0];
        fraction_q <=
          writedata[`USR_FRACTION_LSB+2:`USR_FRACTION_LSB];
      end else if (address == `USR_OFS_RX_IDLE_LIMIT) begin
        idleLimit_q <= writedata[IDLE_W-1:0];
      end else if (address == `USR_OFS_TX_GAP) begin
        gapCount_q <= writedata[GAP_W-1:0];
      end
    end
  end

  // holding registers; a new character wins over the shifter taking one
  always @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      rxHolding_q <= 9'h000;
      charToSend <= 9'h000;
      transmitFreeFlag <= 1'b1;
    end else if (ce) begin
      if (rxCharValid)
        rxHolding_q <= rxChar;
      if (busWrite && address == `USR_OFS_TX_HOLDING) begin
        charToSend <= writedata[8:0];
        transmitFreeFlag <= 1'b0;
      end else if (txCharTaken) begin
        transmitFreeFlag <= 1'b1;
      end
    end
  end

  // lin config: software owns it unless dma mode hands it to dma
  always @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      linCfg_q <= {`USR_LINCFG_W{1'b0}};
    end else if (ce) begin
      if (busWrite && address == `USR_OFS_LIN_CONFIG) begin
        linCfg_q[`USR_LINCFG_DMA_BIT] <=
          writedata[`USR_LINCFG_DMA_BIT];
        if (!dmaMode)
          linCfg_q[15:0] <= writedata[15:0];
      end else if (dmaMode && linDmaValid) begin
        linCfg_q[15:0] <= linDmaData;
      end
    end
  end

  // ident: software in master mode, receiver in slave mode
  always @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      ident_q <= 8'h00;
    end else if (ce) begin
      if (linMaster) begin
        if (busWrite && address == `USR_OFS_LIN_IDENT)
          ident_q <= writedata[7:0];
      end else if (linIdentValid) begin
        ident_q <= linIdentIn;
      end
    end
  end

  // samples per bit from the timing mode
  always @* begin
    if (syncMode)
      samplesPerBit_d = `USR_SAMPLES_SYNC;
    else if (overSample)
      samplesPerBit_d = `USR_SAMPLES_OVER;
    else
      samplesPerBit_d = `USR_SAMPLES_NORMAL;
  end

  usr_baud_gen #(
    .DIV_W(DIV_W)
  ) baudGen (
    .clock(clock),
    .reset_n(reset_n),
    .ce(ce),
    .divisor(divisor_q),
    .fraction(fraction_q),
    .samplesPerBit(samplesPerBit_d),
    .sampleTick(sampleTick),
    .bitTick(bitTick)
  );

  // idle time-out restarts on command or on each received character
  usr_bit_timer #(
    .W(IDLE_W)
  ) idleTimer (
    .clock(clock),
    .reset_n(reset_n),
    .ce(ce),
    .start(rxStartTimeout || rxCharValid),
    .limit(idleLimit_q),
    .bitTick(bitTick),
    .running(),
    .expire(idleExpire)
  );

  // guard time opens after each finished character
  usr_bit_timer #(
    .W(GAP_W)
  ) gapTimer (
    .clock(clock),
    .reset_n(reset_n),
    .ce(ce),
    .start(txCharDone),
    .limit(gapCount_q),
    .bitTick(bitTick),
    .running(gapRunning),
    .expire()
  );

  // response length: count field, or ident bits 5:4 in the older scheme
  always @* begin
    if (linCfg_q[`USR_LIN_LEN_SRC_BIT]) begin
      case (ident_q[5:4])
        2'h2: respLen_d = 9'h004;
        2'h3: respLen_d = 9'h008;
        default: respLen_d = 9'h002;
      endcase
    end else begin
      respLen_d = {1'b0, linCfg_q[15:8]} + 9'h001;
    end
  end

  // registered status and lin controls toward the framing logic
  always @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      baudSample <= 1'b0;
      baudBit <= 1'b0;
      rxIdleTimedOut <= 1'b0;
      txGapHold <= 1'b0;
      linIdentOut <= 8'h00;
      respByteCount <= 9'h000;
      wakeV20 <= 1'b0;
      wakeV13 <= 1'b0;
      slotTimingOn <= 1'b0;
      checksumEnhanced <= 1'b0;
      checksumOn <= 1'b0;
      parityOn <= 1'b0;
      respTransmit <= 1'b0;
      respReceive <= 1'b0;
    end else if (ce) begin
      baudSample <= sampleTick;
      baudBit <= bitTick;
      // expiry sets even in the cycle a restart clears it
      if (idleExpire && idleLimit_q != {IDLE_W{1'b0}})
        rxIdleTimedOut <= 1'b1;
      else if (rxStartTimeout || idleLimit_q == {IDLE_W{1'b0}})
        rxIdleTimedOut <= 1'b0;
      txGapHold <= gapRunning;
      linIdentOut <= ident_q;
      respByteCount <= respLen_d;
      wakeV20 <= sendWakeCmd &&
        !linCfg_q[`USR_LIN_WAKE_KIND_BIT];
      wakeV13 <= sendWakeCmd &&
        linCfg_q[`USR_LIN_WAKE_KIND_BIT];
      slotTimingOn <= !linCfg_q[`USR_LIN_SLOT_OFF_BIT];
      checksumEnhanced <=
        !linCfg_q[`USR_LIN_CHECKSUM_KIND_BIT];
      checksumOn <= !linCfg_q[`USR_LIN_CHECKSUM_OFF_BIT];
      parityOn <= !linCfg_q[`USR_LIN_PARITY_OFF_BIT];
      // reserved role 3 acts as ignore so the line stays quiet
      respTransmit <= (role == `USR_ROLE_PUBLISH);
      respReceive <= (role == `USR_ROLE_SUBSCRIBE);
    end
  end
endmodule

// ===== verification/usr_regs_assertions.sv
`timescale 1ns/1ns
module usr_regs_checker (
  input wire clock,
  input wire reset_n,
  input wire ce,
  input wire [7:0] address,
  input wire read,
  input wire write,
  input wire [31:0] writedata,
  input wire [31:0] readdata,
  input wire waitrequest,
  input wire txCharTaken,
  input wire sendWakeCmd,
  input wire [8:0] charToSend,
  input wire transmitFreeFlag,
  input wire wakeV20,
  input wire wakeV13,
  input wire respTransmit,
  input wire respReceive,
  input wire guardOn
);
  // single clock domain, so clock and reset are given once
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!reset_n);
  // answer edge, where write effects land and read data stand
  wire ans = !waitrequest && ce;
  a_wait_answer: assert property (ce && waitrequest && (read || write)
    |=> !waitrequest) else $error("request not answered");
  a_wait_single: assert property (ce && !waitrequest |=> waitrequest)
    else $error("waitrequest low too long");
  a_rx_upper_zero: assert property (
    ans && read && address == 8'h18 |-> readdata[31:9] == 23'h0)
    else $error("rx upper bits set");
  a_tx_hold_char: assert property (
    ans && write && address == 8'h1C
    |=> !transmitFreeFlag && charToSend == $past(writedata[8:0]))
    else $error("tx char not held");
  a_tx_free_taken: assert property (
    ce && txCharTaken && !(ans && write && address == 8'h1C)
    |=> transmitFreeFlag) else $error("free flag not set");
  a_key_reads_zero: assert property (
    ans && read && address == 8'hE4 |-> readdata[31:1] == 31'h0)
    else $error("key bits not zero");
  a_guard_key: assert property ($changed(guardOn) |->
    $past(ans && write && address == 8'hE4 &&
    writedata[31:8] == 24'h555341)) else $error("guard changed sans key");
  a_wake_follow: assert property (ce && sendWakeCmd
    |-> ##[1:2] (wakeV20 || wakeV13)) else $error("no wake pulse");
  a_wake_excl: assert property (!(wakeV20 && wakeV13))
    else $error("both wake kinds");
  a_role_excl: assert property (!(respTransmit && respReceive))
    else $error("role both ways");
endmodule
bind usr_regs usr_regs_checker chk (.*);

// ===== verification/usr_far_node.sv
`timescale 1ns/1ns
module usr_far_node (
  input wire clock,
  input wire reset_n,
  input wire transmitFreeFlag,
  output logic rxCharValid,
  output logic [8:0] rxChar,
  output logic txCharTaken,
  output logic txCharDone,
  output logic linIdentValid,
  output logic [7:0] linIdentIn
);
  int lag = 1;
  // data lines show junk outside their strobe, never the last value
  initial begin
    {rxCharValid, txCharTaken, txCharDone, linIdentValid} = 4'h0;
    rxChar = 9'h155;
    linIdentIn = 8'hA5;
  end
  task automatic rx_char(input [8:0] c);
    @(posedge clock);
    rxCharValid <= 1'b1;
    rxChar <= c;
    @(posedge clock);
    rxCharValid <= 1'b0;
    rxChar <= ~c;
  endtask
  task automatic rx_ident(input [7:0] c);
    @(posedge clock);
    linIdentValid <= 1'b1;
    linIdentIn <= c;
    @(posedge clock);
    linIdentValid <= 1'b0;
    linIdentIn <= ~c;
  endtask
  // shifter takes a waiting char after lag cycles, then ends it
  always @(posedge clock) begin
    if (reset_n && !transmitFreeFlag) begin
      repeat (lag) @(posedge clock);
      txCharTaken <= 1'b1;
      @(posedge clock);
      txCharTaken <= 1'b0;
      repeat (4) @(posedge clock);
      txCharDone <= 1'b1;
      @(posedge clock);
      txCharDone <= 1'b0;
    end
  end
endmodule

// ===== verification/usr_regs_tb_top.sv
`timescale 1ns/1ns
module usr_regs_tb_top;
  logic clock = 0, reset_n = 0, ce = 1, read = 0, write = 0;
  logic syncMode = 0, overSample = 0, linMaster = 1, rxStartTimeout = 0;
  logic linDmaValid = 0, sendWakeCmd = 0;
  logic [7:0] address = 0;
  logic [31:0] writedata = 0;
  logic [15:0] linDmaData = 0;
  wire [31:0] readdata;
  wire [8:0] rxChar, charToSend, respByteCount;
  wire [7:0] linIdentIn, linIdentOut;
  wire waitrequest, rxCharValid, txCharTaken, txCharDone, linIdentValid;
  wire transmitFreeFlag, baudSample, baudBit, rxIdleTimedOut, txGapHold;
  wire wakeV20, wakeV13, slotTimingOn, checksumEnhanced, checksumOn;
  wire parityOn, respTransmit, respReceive, guardOn;
  int fails = 0, n_compared = 0, t;
  bit gOn = 0;
  logic [31:0] q, d;
  logic [31:0] mdl[logic [7:0]];
  logic [31:0] msk[logic [7:0]];
  logic [7:0] offs[9] = '{8'h18, 8'h1C, 8'h20, 8'h24, 8'h28, 8'h54, 8'h58,
    8'hE4, 8'h30};
  usr_regs DUT (.*);
  usr_far_node node (.*);
  always #2 clock = ~clock;
  task automatic chk(input string s, input [31:0] e, input [31:0] g);
    n_compared++;
    if (g !== e) begin
      fails++;
      $display("mismatch %s expected %h seen %h", s, e, g);
    end
  endtask
  // one transfer, held until waitrequest is seen low
  task automatic bus(input bit w, input [7:0] a, input [31:0] v);
    int n = 0;
    @(posedge clock);
    read <= !w;
    write <= w;
    address <= a;
    writedata <= v;
    do begin
      @(posedge clock);
      n++;
    end while (waitrequest && n < 50);
    if (n >= 50) chk("waitrequest", 0, 1);
    q = readdata;
    read <= 1'b0;
    write <= 1'b0;
  endtask
  // write plus the register model's view of it
  task automatic wr(input [7:0] a, input [31:0] v);
    bus(1, a, v);
    if (a == 8'hE4 && v[31:8] == 24'h555341) gOn = v[0];
    else if (a == 8'h54 && mdl[a][16]) mdl[a][16] = v[16];
    else if (msk.exists(a) && !(gOn && a inside {8'h20, 8'h24, 8'h28})
      && (a != 8'h58 || linMaster)) mdl[a] = v & msk[a];
  endtask
  task automatic rd(input [7:0] a);
    bus(0, a, 0);
    chk("readback", a == 8'hE4 ? gOn : mdl[a], q);
    if (a == 8'hE4) chk("guard", gOn, guardOn);
  endtask
  task automatic sweep();
    d = $urandom & 32'h1FF;
    node.rx_char(d[8:0]);
    mdl[8'h18] = d;
    foreach (offs[i]) wr(offs[i], $urandom);
    foreach (offs[i]) rd(offs[i]);
    $display("test sweep done");
  endtask
  // time the tenth bit period, once the new divisor has settled
  task automatic baud(input [31:0] v, input s, input o, input int e);
    int sc;
    syncMode <= s;
    overSample <= o;
    wr(8'h20, v);
    repeat (10) begin
      t = 0;
      sc = 0;
      do begin
        @(posedge clock);
        t++;
        sc += baudSample;
      end while (!baudBit && t < 3000);
    end
    chk("baud", e, t);
    chk("samples", s ? 1 : o ? 8 : 16, sc);
  endtask
  function automatic [8:0] cnt(input [31:0] c);
    logic [1:0] f;
    f = mdl[8'h58][5:4];
    cnt = !c[5] ? c[15:8] + 9'h1 : f == 2'h3 ? 9'h8 : f == 2'h2 ? 9'h4 : 9'h2;
  endfunction
  task automatic end_sim();
    $display("compared %0d mismatches %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  // watchdog, far beyond the few thousand cycles the tests need
  initial begin
    #200000;
    fails++;
    end_sim();
  end
  initial begin
    foreach (offs[i]) mdl[offs[i]] = 32'h0;
    msk[8'h20] = 32'h7FFFF;
    msk[8'h24] = 32'h1FFFF;
    msk[8'h28] = 32'hFF;
    msk[8'h54] = 32'h1FFFF;
    msk[8'h58] = 32'hFF;
    void'($urandom(78806));
    repeat (5) @(posedge clock);
    reset_n <= 1'b1;
    foreach (offs[i]) rd(offs[i]);
    sweep();
    wr(8'hE4, 32'h55534101);
    sweep();
    wr(8'hE4, 32'h0);
    rd(8'hE4);
    wr(8'hE4, 32'h55534100);
    sweep();
    linMaster <= 1'b0;
    wr(8'h58, $urandom);
    d = $urandom;
    node.rx_ident(d[7:0]);
    mdl[8'h58] = d & 32'hFF;
    rd(8'h58);
    chk("ident", mdl[8'h58], linIdentOut);
    linMaster <= 1'b1;
    wr(8'h58, $urandom);
    for (int i = 0; i < 4; i++) begin
      d = $urandom & 32'hFFDC | i | (i << 5);
      wr(8'h54, d);
      repeat (2) @(negedge clock);
      d = mdl[8'h54];
      chk("lin", {~d[6], ~d[4], ~d[3], ~d[2], d[1:0] == 2'h0, d[1:0] == 2'h1,
        cnt(d)}, {slotTimingOn, checksumEnhanced, checksumOn, parityOn,
        respTransmit, respReceive, respByteCount});
    end
    for (int k = 0; k < 2; k++) begin
      wr(8'h54, k << 7);
      sendWakeCmd <= 1'b1;
      @(posedge clock);
      sendWakeCmd <= 1'b0;
      q = 0;
      repeat (3) begin
        @(posedge clock);
        q = q | {wakeV13, wakeV20};
      end
      chk("wake", 1 << k, q);
    end
    wr(8'h54, 32'h100AB);
    wr(8'h54, 32'h10012);
    d = $urandom;
    linDmaData <= d[15:0];
    linDmaValid <= 1'b1;
    @(posedge clock);
    linDmaValid <= 1'b0;
    mdl[8'h54] = {15'h0, 1'b1, d[15:0]};
    rd(8'h54);
    wr(8'h54, 32'h0);
    $display("test lin done");
    wr(8'h20, 32'h0);
    // a tick already in the pipe may still surface right after the write
    repeat (4) @(posedge clock);
    t = 0;
    repeat (300) @(posedge clock) t += baudBit;
    chk("baud off", 0, t);
    baud(32'h2, 0, 0, 32);
    baud(32'h2, 0, 1, 16);
    baud(32'h5, 1, 0, 5);
    baud(32'h70002, 0, 1, 23);
    baud(32'h2, 1, 0, 2);
    // low enable freezes every flop, so the bit pulse cannot move
    ce <= 1'b0;
    @(posedge clock);
    t = 0;
    repeat (20) @(posedge clock) t += baudBit;
    ce <= 1'b1;
    chk("freeze", 1, t == 0 || t == 20);
    $display("test baud done");
    for (int l = 0; l < 12; l += 6) begin
      wr(8'h24, l);
      rxStartTimeout <= 1'b1;
      @(posedge clock);
      rxStartTimeout <= 1'b0;
      t = 0;
      while (!rxIdleTimedOut && t < 99) begin
        @(posedge clock);
        t++;
      end
      // a zero limit must never raise the flag
      chk("idle", 1,
        l ? t inside {[2 * l - 2:2 * l + 4]} : t == 99);
    end
    for (int g = 0; g < 8; g += 4) begin
      repeat (40) @(posedge clock);
      wr(8'h28, g);
      wr(8'h1C, 32'h0AA);
      // count from two edges after done, so an old gap cannot leak in
      @(posedge clock iff txCharDone);
      @(posedge clock);
      t = 0;
      repeat (60) @(posedge clock) t += txGapHold;
      // the first bit period may be partial, so the run is 2g-1 or 2g
      chk("gap", 1, (t - 2 * g) inside {[-1:1]});
    end
    node.lag = 20;
    d = $urandom & 32'h1FF;
    wr(8'h1C, d);
    repeat (10) @(negedge clock);
    chk("tx held", {1'b0, d[8:0]}, {transmitFreeFlag, charToSend});
    repeat (20) @(negedge clock);
    chk("tx free", 1, transmitFreeFlag);
    $display("test timing done");
    end_sim();
  end
endmodule
